// ===== rtl/engage_pkg.sv
// Constants, types and register map of the engagement state machine.
// Assumes a single 50 MHz system clock and a 32-bit Avalon-MM register bus.
package engage_pkg;

  localparam int unsigned CLK_KHZ = 50000;
  // Fade-on ramp length and warning flash half period, in milliseconds
  localparam int unsigned FADE_MS = 2500;
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FADE_CYCLES = FADE_MS * CLK_KHZ;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned FLASH_COUNT = 4;
  localparam int unsigned RAMP_STEPS = 256;

  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLEAR_OFS = 8'h0c;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'h10;

  // Reset values
  localparam logic CONTROL_RST = 1'b0;
  localparam logic [3:0] IRQ_ENABLE_RST = 4'h0;

  // Event bit positions, shared by status, clear and enable registers
  localparam int unsigned EV_CHANGE = 0;
  localparam int unsigned EV_WARN = 1;
  localparam int unsigned EV_REFUSED = 2;
  localparam int unsigned EV_FORCED = 3;
  localparam int unsigned EV_BITS = 4;

  typedef enum logic [2:0] {
    ALL_OFF,
    FD_ONLY,
    YD_ONLY,
    FD_YD,
    AP_ENGAGED,
    AP_OVERRIDE
  } engage_state_t;

  // Cockpit switches and health lines, all asynchronous to clk
  typedef struct packed {
    logic fdButton;
    logic ydEngage;
    logic apEngage;
    logic goAround;
    logic wheel_steering_override;
    logic manualTrim;
    logic dumpSwitch;
    logic gyroValid;
    logic trimOk;
    logic bitOk;
    logic servoPaddle;
  } switches_t;

  typedef struct packed {
    logic fdLamp;
    logic ydLamp;
    logic apLamp;
  } lamps_t;

endpackage

// ===== rtl/autopilot_engage.sv
// Flight director, yaw damper and autopilot engagement state machine.
// Switch inputs are asynchronous pins; registers sit on Avalon-MM with waitrequest.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
module autopilot_engage #(
  parameter int unsigned FADE_CYCLES = engage_pkg::FADE_CYCLES,
  parameter int unsigned FLASH_HALF_CYCLES = engage_pkg::FLASH_HALF_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // Cockpit inputs
  input wire engage_pkg::switches_t switches,
  // Solenoids, servos, display
  output logic ydSolenoidEn,
  output logic apSolenoidEn,
  output logic servoEngage,
  output engage_pkg::lamps_t lamps,
  output logic barsOutOfView,
  output logic fadeActive,
  output logic [7:0] fadeLevel,
  output logic warnHorn
);

  localparam int unsigned STEP_CYCLES = FADE_CYCLES / engage_pkg::RAMP_STEPS;
  localparam int unsigned STEP_LEN = (STEP_CYCLES < 1) ? 1 : STEP_CYCLES;

  engage_pkg::switches_t syncA;
  engage_pkg::switches_t syncB;
  engage_pkg::switches_t prevSw;
  engage_pkg::engage_state_t state;
  engage_pkg::engage_state_t next_state;
  logic fdPress;
  logic ydRise;
  logic ydFall;
  logic apRise;
  logic apFall;
  logic gaRise;
  logic startFade;
  logic startWarn;
  logic refused;
  logic softEngage;
  logic [engage_pkg::EV_BITS-1:0] irqStatus;
  logic [engage_pkg::EV_BITS-1:0] irqEnable;
  logic [engage_pkg::EV_BITS-1:0] events;
  logic fdOn;
  logic ydOn;
  logic apOn;
  logic forced;
  logic next_ydSol;
  logic next_apSol;
  logic [31:0] stepCnt;
  logic [31:0] flashCnt;
  logic [3:0] flashPhase;
  logic flashing;

  // Two-stage synchroniser, then a third stage for edge detection
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      syncA <= '0;
      syncB <= '0;
      prevSw <= '0;
    end
    else
    begin
      syncA <= switches;
      syncB <= syncA;
      prevSw <= syncB;
    end
  end

  assign fdPress = syncB.fdButton && !prevSw.fdButton;
  assign ydRise = syncB.ydEngage && !prevSw.ydEngage;
  assign ydFall = !syncB.ydEngage && prevSw.ydEngage;
  assign apRise = syncB.apEngage && !prevSw.apEngage;
  assign apFall = !syncB.apEngage && prevSw.apEngage;
  assign gaRise = syncB.goAround && !prevSw.goAround;

  // Next engagement state; coincident events are taken in priority order, earlier tests winning
  always_comb
  begin
    next_state = state;
    startFade = 1'b0;
    startWarn = 1'b0;
    refused = 1'b0;
    case (state)
      engage_pkg::ALL_OFF:
      begin
        if (fdPress)
          next_state = engage_pkg::FD_ONLY;
        else if (ydRise || apRise)
          next_state = engage_pkg::YD_ONLY;
        refused = apRise;
      end
      engage_pkg::FD_ONLY:
      begin
        if (fdPress)
          next_state = engage_pkg::ALL_OFF;
        else if (apRise)
        begin
          next_state = engage_pkg::AP_ENGAGED;
          startFade = 1'b1;
        end
        else if (ydRise)
          next_state = engage_pkg::FD_YD;
      end
      engage_pkg::YD_ONLY:
      begin
        if (ydFall)
          next_state = engage_pkg::ALL_OFF;
        else if (fdPress)
          next_state = engage_pkg::FD_YD;
        refused = apRise;
      end
      engage_pkg::FD_YD:
      begin
        if (ydFall)
          next_state = engage_pkg::FD_ONLY;
        else if (fdPress)
          next_state = engage_pkg::YD_ONLY;
        else if (apRise)
        begin
          next_state = engage_pkg::AP_ENGAGED;
          startFade = 1'b1;
        end
      end
      engage_pkg::AP_ENGAGED, engage_pkg::AP_OVERRIDE:
      begin
        if (ydFall)
        begin
          next_state = engage_pkg::FD_ONLY;
          startWarn = 1'b1;
        end
        else if (apFall || gaRise || fdPress)
        begin
          next_state = fdPress ? engage_pkg::YD_ONLY : engage_pkg::FD_YD;
          startWarn = 1'b1;
        end
        else if (state == engage_pkg::AP_ENGAGED && syncB.wheel_steering_override)
          next_state = engage_pkg::AP_OVERRIDE;
        else if (state == engage_pkg::AP_OVERRIDE && !syncB.wheel_steering_override)
        begin
          next_state = engage_pkg::AP_ENGAGED;
          startFade = 1'b1;
        end
      end
      default:
        next_state = engage_pkg::ALL_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      state <= engage_pkg::ALL_OFF;
    else
      state <= next_state;
  end

  assign fdOn = state == engage_pkg::FD_ONLY || state == engage_pkg::FD_YD || apOn;
  assign ydOn = state == engage_pkg::YD_ONLY || state == engage_pkg::FD_YD || apOn;
  assign apOn = state == engage_pkg::AP_ENGAGED || state == engage_pkg::AP_OVERRIDE;

  // Forced disengagements other than go-around act only on the solenoid enables
  always_comb
  begin
    next_ydSol = ydOn && syncB.gyroValid && syncB.bitOk && !syncB.dumpSwitch;
    next_apSol = apOn && syncB.gyroValid && syncB.bitOk && !syncB.dumpSwitch
      && !syncB.goAround && syncB.trimOk
      && !(syncB.manualTrim && !syncB.wheel_steering_override);
  end

  assign forced = (ydSolenoidEn && !next_ydSol && ydOn) || (apSolenoidEn && !next_apSol && apOn);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ydSolenoidEn <= 1'b0;
      apSolenoidEn <= 1'b0;
      servoEngage <= 1'b0;
      barsOutOfView <= 1'b1;
    end
    else
    begin
      ydSolenoidEn <= next_ydSol;
      apSolenoidEn <= next_apSol;
      servoEngage <= state == engage_pkg::AP_ENGAGED && softEngage
        && syncB.servoPaddle;
      barsOutOfView <= state == engage_pkg::ALL_OFF || state == engage_pkg::YD_ONLY;
    end
  end

  // Fade-on ramp, restarted by each flagged transition
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fadeActive <= 1'b0;
      fadeLevel <= 8'h00;
      stepCnt <= '0;
    end
    else if (startFade)
    begin
      fadeActive <= 1'b1;
      fadeLevel <= 8'h00;
      stepCnt <= '0;
    end
    else if (!apOn)
    begin
      fadeActive <= 1'b0;
      fadeLevel <= 8'h00;
    end
    else if (fadeActive)
    begin
      if (stepCnt == STEP_LEN - 1)
      begin
        stepCnt <= '0;
        if (fadeLevel == 8'hff)
          fadeActive <= 1'b0;
        else
          fadeLevel <= fadeLevel + 8'h01;
      end
      else
        stepCnt <= stepCnt + 32'h1;
    end
  end

  // Warning: four lamp flashes with the horn sounding throughout
  assign flashing = flashPhase != 4'h0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      flashPhase <= 4'h0;
      flashCnt <= '0;
      warnHorn <= 1'b0;
    end
    else if (startWarn)
    begin
      flashPhase <= 4'(2 * engage_pkg::FLASH_COUNT);
      flashCnt <= '0;
      warnHorn <= 1'b1;
    end
    else if (flashing)
    begin
      if (flashCnt == FLASH_HALF_CYCLES - 1)
      begin
        flashCnt <= '0;
        flashPhase <= flashPhase - 4'h1;
        warnHorn <= flashPhase != 4'h1;
      end
      else
        flashCnt <= flashCnt + 32'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      lamps <= '0;
    else
    begin
      lamps.fdLamp <= fdOn;
      lamps.ydLamp <= ydOn;
      lamps.apLamp <= flashing ? flashPhase[0] == 1'b1 : apOn;
    end
  end

  // Interrupt events: set wins over clear
  assign events = {forced, refused, startWarn, next_state != state};

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irqStatus <= '0;
    else if (write && !waitrequest && address == engage_pkg::IRQ_CLEAR_OFS && byteenable[0])
      irqStatus <= (irqStatus & ~writedata[engage_pkg::EV_BITS-1:0]) | events;
    else
      irqStatus <= irqStatus | events;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqEnable);
  end

  // Register writes take effect on the edge where waitrequest is seen low
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      softEngage <= engage_pkg::CONTROL_RST;
      irqEnable <= engage_pkg::IRQ_ENABLE_RST;
    end
    else if (write && !waitrequest && byteenable[0])
    begin
      if (address == engage_pkg::CONTROL_OFS)
        softEngage <= writedata[0];
      else if (address == engage_pkg::IRQ_ENABLE_OFS)
        irqEnable <= writedata[engage_pkg::EV_BITS-1:0];
    end
  end

  // One wait cycle per access; read data latched while waitrequest is high
  always_ff @(posedge clk)
  begin
    if (!nrst)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      readdata <= 32'h0;
    else if (read && waitrequest)
    begin
      if (address == engage_pkg::STATUS_OFS)
        readdata <= {20'h0, fadeActive, warnHorn, servoEngage, apSolenoidEn,
          ydSolenoidEn, lamps, 1'b0, state};
      else if (address == engage_pkg::CONTROL_OFS)
        readdata <= {31'h0, softEngage};
      else if (address == engage_pkg::IRQ_STATUS_OFS)
        readdata <= {28'h0, irqStatus};
      else if (address == engage_pkg::IRQ_ENABLE_OFS)
        readdata <= {28'h0, irqEnable};
      else
        readdata <= 32'h0;
    end
  end

endmodule

// ===== dv/autopilot_engage_monitor.sv
// Concurrent checks on the engagement machine's pins.
// Bound into autopilot_engage; inputs pass two sync stages and a register.
module autopilot_engage_monitor #(
  parameter int unsigned FADE_CYCLES = 512,
  parameter int unsigned FLASH_HALF_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched pins
  input wire engage_pkg::switches_t switches,
  input wire logic ydSolenoidEn,
  input wire logic apSolenoidEn,
  input wire logic servoEngage,
  input wire engage_pkg::lamps_t lamps,
  input wire logic barsOutOfView,
  input wire logic fadeActive,
  input wire logic warnHorn
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned fadeCnt;
  int unsigned hornCnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  always_ff @(posedge clk)
    fadeCnt <= (!nrst || !fadeActive) ? 0 : fadeCnt + 1;
  always_ff @(posedge clk)
    hornCnt <= (!nrst || !warnHorn) ? 0 : hornCnt + 1;
  dump_drop_a: assert property (switches.dumpSwitch [*6] |-> !ydSolenoidEn && !apSolenoidEn)
    else $error("dump switch left a solenoid held");
  gyro_drop_a: assert property (!switches.gyroValid [*6] |-> !ydSolenoidEn && !apSolenoidEn)
    else $error("bad gyro left a solenoid held");
  bit_drop_a: assert property (!switches.bitOk [*6] |-> !ydSolenoidEn && !apSolenoidEn)
    else $error("test failure left a solenoid held");
  ap_trim_a: assert property ((!switches.trimOk || switches.goAround) [*6] |-> !apSolenoidEn)
    else $error("autopilot solenoid held through trim fault or go-around");
  manual_trim_a: assert property ((switches.manualTrim && !switches.wheel_steering_override) [*6]
    |-> !apSolenoidEn)
    else $error("autopilot solenoid held during manual trim");
  paddle_servo_a: assert property (!switches.servoPaddle [*6] |-> !servoEngage)
    else $error("servos engaged without paddle engage");
  steer_servo_a: assert property (switches.wheel_steering_override [*6] |-> !servoEngage)
    else $error("servos engaged during steering override");
  ap_lamps_a: assert property (apSolenoidEn |-> ydSolenoidEn && lamps == 3'b111)
    else $error("autopilot enabled without full lamps and yaw damper");
  bars_fd_a: assert property (barsOutOfView |-> !lamps.fdLamp)
    else $error("bars hidden while flight director lit");
  fade_len_a: assert property (fadeCnt <= FADE_CYCLES + 1)
    else $error("fade ramp runs too long");
  horn_len_a: assert property ($fell(warnHorn) |-> hornCnt >= 8 * FLASH_HALF_CYCLES - 2
    && hornCnt <= 8 * FLASH_HALF_CYCLES + 1)
    else $error("warning horn length wrong");
  fade_c: cover property ($rose(fadeActive));
  horn_c: cover property ($rose(warnHorn));
  trim_steer_c: cover property (switches.manualTrim && switches.wheel_steering_override
    && apSolenoidEn);
endmodule

bind autopilot_engage autopilot_engage_monitor #(.FADE_CYCLES(FADE_CYCLES),
  .FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) mon (.clk(clk), .nrst(nrst), .switches(switches),
  .ydSolenoidEn(ydSolenoidEn), .apSolenoidEn(apSolenoidEn), .servoEngage(servoEngage),
  .lamps(lamps), .barsOutOfView(barsOutOfView), .fadeActive(fadeActive), .warnHorn(warnHorn));

// ===== dv/paddle_model.sv
// Solenoid-held, linked yaw damper and autopilot paddle switches.
// A paddle falls once its solenoid has been unpowered for GRACE cycles.
module paddle_model #(
  parameter int unsigned GRACE = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pilot lifts the autopilot paddle
  input wire logic setAp,
  // Solenoid drive
  input wire logic ydSolenoidEn,
  input wire logic apSolenoidEn,
  // Paddle contacts
  output logic ydEngage,
  output logic apEngage,
  output logic servoPaddle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ydLow;
  logic [3:0] apLow;
  assign servoPaddle = apEngage;
  always_ff @(posedge clk)
    ydLow <= (!nrst || ydSolenoidEn || !ydEngage) ? 4'h0 : ydLow + 4'h1;
  always_ff @(posedge clk)
    apLow <= (!nrst || apSolenoidEn || !apEngage) ? 4'h0 : apLow + 4'h1;
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ydEngage <= 1'b0;
      apEngage <= 1'b0;
    end
    else if (setAp)
    begin
      // Autopilot paddle carries the yaw damper paddle
      ydEngage <= 1'b1;
      apEngage <= 1'b1;
    end
    else
    begin
      if (ydLow == 4'(GRACE))
      begin
        ydEngage <= 1'b0;
        apEngage <= 1'b0;
      end
      if (apLow == 4'(GRACE))
        apEngage <= 1'b0;
    end
  end
endmodule

// ===== dv/test_autopilot_engage.sv
// Self-checking bench for autopilot_engage with paddle_model as far side.
// Short fade and flash counts; registers reached over Avalon-MM.
module test_autopilot_engage;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, irq, ydSolenoidEn, apSolenoidEn, servoEngage;
  logic barsOutOfView, fadeActive, warnHorn, ydP, apP, sp, prev;
  logic [7:0] fadeLevel;
  engage_pkg::lamps_t lamps;
  engage_pkg::switches_t switches;
  logic fd = 1'b0;
  logic ws = 1'b0;
  logic mt = 1'b0;
  logic setAp = 1'b0;
  // Fault lines: go-around, trim, trim monitor, dump, gyro, test
  logic [5:0] flt = 6'h00;
  int num_errors = 0;
  int n_checks = 0;
  int n, k;
  always #10 clk = ~clk;
  assign switches = {fd, ydP, apP, flt[0], ws, flt[1] | mt, flt[3], ~flt[4], ~flt[2], ~flt[5], sp};
  autopilot_engage #(.FADE_CYCLES(512), .FLASH_HALF_CYCLES(4)) uut (.clk(clk), .nrst(nrst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hf),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .switches(switches),
    .ydSolenoidEn(ydSolenoidEn), .apSolenoidEn(apSolenoidEn), .servoEngage(servoEngage),
    .lamps(lamps), .barsOutOfView(barsOutOfView), .fadeActive(fadeActive),
    .fadeLevel(fadeLevel), .warnHorn(warnHorn));
  paddle_model cockpit (.clk(clk), .nrst(nrst), .setAp(setAp), .ydSolenoidEn(ydSolenoidEn),
    .apSolenoidEn(apSolenoidEn), .ydEngage(ydP), .apEngage(apP), .servoPaddle(sp));
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task bus_rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task expect_state(input logic [2:0] s);
    bus_rd(engage_pkg::STATUS_OFS);
    check(rd & 32'h7, 32'(s));
  endtask
  // Long press: one toggle however long it is held
  task press;
    fd <= 1'b1;
    cyc(20);
    fd <= 1'b0;
    cyc(10);
  endtask
  task lift;
    setAp <= 1'b1;
    cyc(1);
    setAp <= 1'b0;
    cyc(10);
  endtask
  task finish_test;
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(20000);
    num_errors++;
    finish_test();
  end
  initial
  begin
    cyc(10);
    nrst <= 1'b1;
    cyc(2);
    check(32'({ydSolenoidEn, apSolenoidEn, servoEngage, lamps, barsOutOfView, irq}), 32'h2);
    bus_rd(engage_pkg::STATUS_OFS);
    check(rd, 32'h0);
    bus_rd(engage_pkg::CONTROL_OFS);
    check(rd, 32'h0);
    bus_rd(engage_pkg::IRQ_ENABLE_OFS);
    check(rd, 32'h0);
    bus_rd(8'h20);
    check(rd, 32'h0);
    bus_wr(engage_pkg::IRQ_ENABLE_OFS, 32'h1);
    press();
    check(32'(lamps), 32'h4);
    check(32'(irq), 32'h1);
    bus_rd(engage_pkg::IRQ_STATUS_OFS);
    check(rd & 32'h1, 32'h1);
    bus_wr(engage_pkg::IRQ_CLEAR_OFS, 32'h1);
    cyc(3);
    check(32'(irq), 32'h0);
    bus_wr(engage_pkg::IRQ_ENABLE_OFS, 32'h0);
    press();
    expect_state(engage_pkg::ALL_OFF);
    lift();
    expect_state(engage_pkg::YD_ONLY);
    check(32'({ydSolenoidEn, apSolenoidEn, lamps, barsOutOfView}), 32'h25);
    cyc(20);
    press();
    expect_state(engage_pkg::FD_YD);
    check(32'({ydSolenoidEn, apSolenoidEn, lamps, barsOutOfView}), 32'h2c);
    bus_wr(engage_pkg::CONTROL_OFS, 32'h1);
    setAp <= 1'b1;
    cyc(1);
    setAp <= 1'b0;
    n = 0;
    while (fadeActive !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (fadeActive === 1'b1 && n < 2000)
    begin
      cyc(1);
      n++;
    end
    check(32'(n >= 511 && n <= 513), 32'h1);
    check(32'(fadeLevel), 32'hff);
    check(32'({ydSolenoidEn, apSolenoidEn, servoEngage, lamps}), 32'h3f);
    expect_state(engage_pkg::AP_ENGAGED);
    bus_wr(engage_pkg::CONTROL_OFS, 32'h0);
    cyc(5);
    check(32'(servoEngage), 32'h0);
    bus_wr(engage_pkg::CONTROL_OFS, 32'h1);
    cyc(5);
    check(32'(servoEngage), 32'h1);
    ws <= 1'b1;
    cyc(10);
    expect_state(engage_pkg::AP_OVERRIDE);
    check(32'(servoEngage), 32'h0);
    mt <= 1'b1;
    cyc(10);
    check(32'(apSolenoidEn), 32'h1);
    ws <= 1'b0;
    cyc(5);
    check(32'({ydSolenoidEn, apSolenoidEn}), 32'h2);
    n = 0;
    while (warnHorn !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    k = 0;
    prev = lamps.apLamp;
    while (warnHorn === 1'b1 && n < 300)
    begin
      cyc(1);
      n++;
      if (lamps.apLamp === 1'b1 && prev === 1'b0)
        k++;
      prev = lamps.apLamp;
    end
    check(32'(k), 32'h4);
    mt <= 1'b0;
    cyc(40);
    expect_state(engage_pkg::FD_YD);
    for (int f = 0; f < 6; f++)
    begin
      lift();
      expect_state(engage_pkg::AP_ENGAGED);
      flt <= 6'h1 << f;
      cyc(10);
      check(32'({ydSolenoidEn, apSolenoidEn}), f < 3 ? 32'h2 : 32'h0);
      cyc(10);
      flt <= 6'h00;
      cyc(60);
      expect_state(f < 3 ? engage_pkg::FD_YD : engage_pkg::FD_ONLY);
    end
    // Warning, refused engage and forced drop all seen since the early clear
    bus_rd(engage_pkg::IRQ_STATUS_OFS);
    check(rd, 32'hf);
    bus_wr(engage_pkg::IRQ_CLEAR_OFS, 32'hf);
    bus_rd(engage_pkg::IRQ_STATUS_OFS);
    check(rd, 32'h0);
    finish_test();
  end
endmodule
